// >>> common/lsx_pkg.sv
package lsx_pkg;
  localparam int LSX_NREG = 32;
  localparam int LSX_AW = 16;
  // low byte of each pointer pair
  localparam logic [4:0] LSX_PTR_X_LO = 5'h1a;
  localparam logic [4:0] LSX_PTR_Y_LO = 5'h1c;
  localparam logic [4:0] LSX_PTR_Z_LO = 5'h1e;
  // flag register bit positions
  localparam int LSX_FLAG_C = 0;
  localparam int LSX_FLAG_Z = 1;
  localparam int LSX_FLAG_N = 2;
  localparam int LSX_FLAG_V = 3;
  localparam int LSX_FLAG_S = 4;
  localparam int LSX_FLAG_H = 5;
  localparam int LSX_FLAG_T = 6;
  localparam int LSX_FLAG_I = 7;
  localparam int LSX_MSB = 7;
  localparam logic [7:0] LSX_FLAGS_RESET = 8'h00;
  localparam logic [15:0] LSX_SP_RESET = 16'h00ff;
  // register port map beyond the register file
  localparam logic [5:0] LSX_CFG_FLAGS = 6'h20;
  localparam logic [5:0] LSX_CFG_SP_LO = 6'h21;
  localparam logic [5:0] LSX_CFG_SP_HI = 6'h22;

  typedef enum logic [4:0] {
    LSX_OP_NOP, LSX_OP_LOAD_INDIRECT, LSX_OP_LOAD_DIRECT, LSX_OP_MEMORY_WRITE_INDIRECT,
    LSX_OP_WRITE_DIRECT, LSX_OP_PROGRAM_MEMORY_READ, LSX_OP_PUSH, LSX_OP_POP,
    LSX_OP_IO_BIT_SET, LSX_OP_IO_BIT_CLEAR, LSX_OP_LOGICAL_SHIFT_LEFT,
    LSX_OP_LOGICAL_SHIFT_RIGHT, LSX_OP_ROTATE_LEFT_CARRY, LSX_OP_ROTATE_RIGHT_CARRY,
    LSX_OP_ARITH_SHIFT_RIGHT, LSX_OP_BIT_TO_FLAG_COPY, LSX_OP_FLAG_TO_BIT_COPY,
    LSX_OP_FLAG_SET, LSX_OP_FLAG_CLEAR, LSX_OP_SLEEP, LSX_OP_WATCHDOG_RESTART, LSX_OP_BREAK
  } lsx_op_e;

  typedef enum logic [1:0] {LSX_PTR_X, LSX_PTR_Y, LSX_PTR_Z} lsx_ptr_e;
  typedef enum logic [1:0] {LSX_AM_PLAIN, LSX_AM_POSTINC, LSX_AM_PREDEC, LSX_AM_DISP} lsx_amode_e;
  typedef enum logic [1:0] {LSX_S_IDLE = 2'b00, LSX_S_WAIT1 = 2'b01, LSX_S_WAIT2 = 2'b11} lsx_state_e;

  typedef struct packed {
    lsx_op_e op;
    lsx_ptr_e ptr;
    lsx_amode_e amode;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [5:0] disp;
    logic [LSX_AW-1:0] addr;
    logic [5:0] io;
    logic [2:0] bitsel;
  } lsx_instr_s;

  typedef struct packed {
    logic [LSX_AW-1:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } lsx_dm_req_s;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } lsx_io_req_s;
endpackage : lsx_pkg

// >>> core/lsx_exec.sv
`timescale 1ns/1ps
`default_nettype none
module lsx_exec
  import lsx_pkg::*;
#(
  parameter logic [15:0] SP_RESET = LSX_SP_RESET
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // instruction handshake
  input wire logic instr_valid,
  input wire lsx_instr_s instr,
  output logic ready,
  output logic done,
  // data memory
  output lsx_dm_req_s dm_req,
  input wire logic [7:0] dm_rdata,
  // io registers
  output lsx_io_req_s io_req,
  input wire logic [7:0] io_rdata,
  // program memory
  output logic [LSX_AW-1:0] pm_addr,
  output logic pm_re,
  input wire logic [7:0] pm_rdata,
  // control pulses
  output logic sleep_req,
  output logic wdr_pulse,
  output logic break_req,
  // flag register view
  output logic [7:0] flags,
  // register port
  input wire logic [5:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_we,
  input wire logic cfg_re,
  output logic [7:0] cfg_rdata
);

  function automatic logic [4:0] ptr_lo(input lsx_ptr_e p);
    unique case (p)
      LSX_PTR_X: ptr_lo = LSX_PTR_X_LO;
      LSX_PTR_Y: ptr_lo = LSX_PTR_Y_LO;
      LSX_PTR_Z: ptr_lo = LSX_PTR_Z_LO;
      default: ptr_lo = LSX_PTR_Z_LO;
    endcase
  endfunction : ptr_lo

  function automatic logic [7:0] bit_put(input logic [7:0] v, input logic [2:0] b, input logic x);
    bit_put = v;
    bit_put[b] = x;
  endfunction : bit_put

  function automatic logic is_dm_rd(input lsx_op_e op);
    is_dm_rd = op == LSX_OP_LOAD_INDIRECT || op == LSX_OP_LOAD_DIRECT || op == LSX_OP_POP;
  endfunction : is_dm_rd

  function automatic logic is_dm_wr(input lsx_op_e op);
    is_dm_wr = op == LSX_OP_MEMORY_WRITE_INDIRECT || op == LSX_OP_WRITE_DIRECT || op == LSX_OP_PUSH;
  endfunction : is_dm_wr

  function automatic logic is_io(input lsx_op_e op);
    is_io = op == LSX_OP_IO_BIT_SET || op == LSX_OP_IO_BIT_CLEAR;
  endfunction : is_io

  // {carry out, result}
  function automatic logic [8:0] shift_fn(input lsx_op_e op, input logic [7:0] v, input logic c);
    unique case (op)
      LSX_OP_LOGICAL_SHIFT_LEFT: shift_fn = {v[LSX_MSB], v[6:0], 1'b0};
      LSX_OP_ROTATE_LEFT_CARRY: shift_fn = {v[LSX_MSB], v[6:0], c};
      LSX_OP_LOGICAL_SHIFT_RIGHT: shift_fn = {v[0], 1'b0, v[7:1]};
      LSX_OP_ROTATE_RIGHT_CARRY: shift_fn = {v[0], c, v[7:1]};
      LSX_OP_ARITH_SHIFT_RIGHT: shift_fn = {v[0], v[LSX_MSB], v[7:1]};
      default: shift_fn = {c, v};
    endcase
  endfunction : shift_fn

  logic [7:0] rf_reg [LSX_NREG];
  logic [7:0] rf_next [LSX_NREG];
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [15:0] sp_reg;
  logic [15:0] sp_next;
  lsx_state_e state_reg;
  lsx_state_e state_next;
  lsx_instr_s op_reg;
  lsx_instr_s instr_eff;
  lsx_dm_req_s dm_req_reg;
  lsx_dm_req_s dm_next;
  lsx_io_req_s io_req_reg;
  lsx_io_req_s io_next;
  logic [15:0] pm_addr_reg;
  logic pm_re_reg;
  logic ready_reg;
  logic done_reg;
  logic sleep_reg;
  logic wdr_reg;
  logic break_reg;
  logic [7:0] cfg_rdata_reg;

  // decode of the presented instruction
  wire logic go = instr_valid && ready_reg;
  wire logic op_pm = instr.op == LSX_OP_PROGRAM_MEMORY_READ;
  wire logic op_ind = instr.op == LSX_OP_LOAD_INDIRECT || instr.op == LSX_OP_MEMORY_WRITE_INDIRECT;
  wire logic op_shift = instr.op inside {LSX_OP_LOGICAL_SHIFT_LEFT, LSX_OP_LOGICAL_SHIFT_RIGHT,
    LSX_OP_ROTATE_LEFT_CARRY, LSX_OP_ROTATE_RIGHT_CARRY, LSX_OP_ARITH_SHIFT_RIGHT};
  wire logic op_long = is_dm_rd(instr.op) || is_dm_wr(instr.op) || is_io(instr.op) || op_pm;
  // program memory reads always go through pointer_three
  wire lsx_ptr_e ptr_sel = op_pm ? LSX_PTR_Z : instr.ptr;
  wire logic [4:0] plo = ptr_lo(ptr_sel);
  wire logic [4:0] phi = plo + 5'h01;
  wire logic [15:0] ptr_val = {rf_reg[phi], rf_reg[plo]};
  wire logic [15:0] ptr_inc = ptr_val + 16'h0001;
  wire logic [15:0] ptr_dec = ptr_val - 16'h0001;
  wire logic [15:0] disp_ext = {10'h000, instr.disp};
  wire logic is_predec = instr.amode == LSX_AM_PREDEC;
  wire logic ptr_moves = (op_ind && (instr.amode == LSX_AM_POSTINC || is_predec))
    || (op_pm && instr.amode == LSX_AM_POSTINC);
  wire logic [15:0] ptr_new = is_predec ? ptr_dec : ptr_inc;
  wire logic [15:0] ea_ind = is_predec ? ptr_dec
    : (instr.amode == LSX_AM_DISP) ? ptr_val + disp_ext : ptr_val;
  wire logic [15:0] sp_inc = sp_reg + 16'h0001;
  wire logic [15:0] sp_dec = sp_reg - 16'h0001;
  wire logic direct = instr.op == LSX_OP_LOAD_DIRECT || instr.op == LSX_OP_WRITE_DIRECT;
  // push at stack pointer, pop one above
  wire logic [15:0] dm_addr_sel = direct ? instr.addr : (instr.op == LSX_OP_PUSH) ? sp_reg
    : (instr.op == LSX_OP_POP) ? sp_inc : ea_ind;
  wire logic [7:0] src_val = rf_reg[instr.rr];
  wire logic [7:0] dst_val = rf_reg[instr.rd];
  wire logic src_bit = src_val[instr.bitsel];
  wire logic [8:0] sh_res = shift_fn(instr.op, dst_val, flags_reg[LSX_FLAG_C]);
  wire logic held_pm = op_reg.op == LSX_OP_PROGRAM_MEMORY_READ;
  wire logic [4:0] held_lo = ptr_lo(op_reg.ptr);
  wire logic [15:0] held_ptr = {rf_reg[held_lo + 5'h01], rf_reg[held_lo]};
  wire logic rd_hits_ptr = instr.rd[4:1] == plo[4:1];
  // register port decode
  wire logic rf_hit = cfg_addr < 6'(LSX_NREG);
  wire logic [7:0] cfg_rd_mux = rf_hit ? rf_reg[cfg_addr[4:0]]
    : (cfg_addr == LSX_CFG_FLAGS) ? flags_reg
    : (cfg_addr == LSX_CFG_SP_LO) ? sp_reg[7:0]
    : (cfg_addr == LSX_CFG_SP_HI) ? sp_reg[15:8] : 8'h00;

  // data memory request, read data taken next cycle
  assign dm_next = '{addr: dm_addr_sel, wdata: src_val,
    we: go && is_dm_wr(instr.op), re: go && is_dm_rd(instr.op)};
  // read in the first cycle, write back the one bit after it
  assign io_next = '{addr: go ? instr.io : op_reg.io,
    wdata: bit_put(io_rdata, op_reg.bitsel, op_reg.op == LSX_OP_IO_BIT_SET),
    we: state_reg == LSX_S_WAIT1 && is_io(op_reg.op), re: go && is_io(instr.op)};

  always_comb begin
    instr_eff = instr;
    instr_eff.ptr = ptr_sel;
  end

  always_comb begin
    unique case (state_reg)
      LSX_S_IDLE: state_next = (go && op_long) ? LSX_S_WAIT1 : LSX_S_IDLE;
      LSX_S_WAIT1: state_next = held_pm ? LSX_S_WAIT2 : LSX_S_IDLE;
      LSX_S_WAIT2: state_next = LSX_S_IDLE;
      default: state_next = LSX_S_IDLE;
    endcase
  end

  // execution writes come after port writes and win
  always_comb begin
    rf_next = rf_reg;
    flags_next = flags_reg;
    sp_next = sp_reg;
    if (cfg_we && rf_hit) begin
      rf_next[cfg_addr[4:0]] = cfg_wdata;
    end
    if (cfg_we && cfg_addr == LSX_CFG_FLAGS) begin
      flags_next = cfg_wdata;
    end
    if (cfg_we && cfg_addr == LSX_CFG_SP_LO) begin
      sp_next[7:0] = cfg_wdata;
    end
    if (cfg_we && cfg_addr == LSX_CFG_SP_HI) begin
      sp_next[15:8] = cfg_wdata;
    end
    if (go && ptr_moves) begin
      {rf_next[phi], rf_next[plo]} = ptr_new;
    end
    // shifts update zero, carry, negative, overflow
    if (go && op_shift) begin
      rf_next[instr.rd] = sh_res[7:0];
      flags_next[LSX_FLAG_C] = sh_res[8];
      flags_next[LSX_FLAG_N] = sh_res[LSX_MSB];
      flags_next[LSX_FLAG_Z] = sh_res[7:0] == 8'h00;
      flags_next[LSX_FLAG_V] = sh_res[LSX_MSB] ^ sh_res[8];
    end
    if (go && instr.op == LSX_OP_BIT_TO_FLAG_COPY) begin
      flags_next[LSX_FLAG_T] = src_bit;
    end
    if (go && instr.op == LSX_OP_FLAG_TO_BIT_COPY) begin
      rf_next[instr.rd] = bit_put(dst_val, instr.bitsel, flags_reg[LSX_FLAG_T]);
    end
    if (go && instr.op == LSX_OP_FLAG_SET) begin
      flags_next[instr.bitsel] = 1'b1;
    end
    if (go && instr.op == LSX_OP_FLAG_CLEAR) begin
      flags_next[instr.bitsel] = 1'b0;
    end
    if (go && instr.op == LSX_OP_PUSH) begin
      sp_next = sp_dec;
    end
    if (go && instr.op == LSX_OP_POP) begin
      sp_next = sp_inc;
    end
    // load data lands at the end of the second cycle
    if (state_reg == LSX_S_WAIT1 && is_dm_rd(op_reg.op)) begin
      rf_next[op_reg.rd] = dm_rdata;
    end
    // program byte lands at the end of the third cycle
    if (state_reg == LSX_S_WAIT2) begin
      rf_next[op_reg.rd] = pm_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < LSX_NREG; i++) begin
        rf_reg[i] <= 8'h00;
      end
      flags_reg <= LSX_FLAGS_RESET;
      sp_reg <= SP_RESET;
      state_reg <= LSX_S_IDLE;
    end else begin
      rf_reg <= rf_next;
      flags_reg <= flags_next;
      sp_reg <= sp_next;
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      op_reg <= '0;
      dm_req_reg <= '0;
      io_req_reg <= '0;
      pm_addr_reg <= 16'h0000;
      pm_re_reg <= 1'b0;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      op_reg <= go ? instr_eff : op_reg;
      dm_req_reg <= dm_next;
      io_req_reg <= io_next;
      pm_addr_reg <= ptr_val;
      pm_re_reg <= go && op_pm;
      ready_reg <= state_next == LSX_S_IDLE;
      done_reg <= state_next == LSX_S_IDLE && (go || state_reg != LSX_S_IDLE);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sleep_reg <= 1'b0;
      wdr_reg <= 1'b0;
      break_reg <= 1'b0;
      cfg_rdata_reg <= 8'h00;
    end else begin
      sleep_reg <= go && instr.op == LSX_OP_SLEEP;
      wdr_reg <= go && instr.op == LSX_OP_WATCHDOG_RESTART;
      break_reg <= go && instr.op == LSX_OP_BREAK;
      cfg_rdata_reg <= cfg_re ? cfg_rd_mux : 8'h00;
    end
  end

  assign ready = ready_reg;
  assign done = done_reg;
  assign dm_req = dm_req_reg;
  assign io_req = io_req_reg;
  assign pm_addr = pm_addr_reg;
  assign pm_re = pm_re_reg;
  assign sleep_req = sleep_reg;
  assign wdr_pulse = wdr_reg;
  assign break_req = break_reg;
  assign flags = flags_reg;
  assign cfg_rdata = cfg_rdata_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_load_two;
    go && is_dm_rd(instr.op) |=> dm_req.re && !ready ##1 ready && done;
  endproperty
  a_load_two: assert property (p_load_two) else $error("load not two cycles");

  property p_postinc;
    go && instr.op == LSX_OP_LOAD_INDIRECT && instr.amode == LSX_AM_POSTINC && !rd_hits_ptr
      |=> dm_req.addr == $past(ptr_val) ##1 held_ptr == $past(ptr_inc, 2);
  endproperty
  a_postinc: assert property (p_postinc) else $error("post-increment load wrong");

  property p_predec;
    go && op_ind && is_predec && !rd_hits_ptr |=> dm_req.addr == $past(ptr_dec) && held_ptr == dm_req.addr;
  endproperty
  a_predec: assert property (p_predec) else $error("pre-decrement address wrong");

  property p_disp;
    go && op_ind && instr.amode == LSX_AM_DISP && !rd_hits_ptr
      |=> dm_req.addr == $past(ptr_val) + $past(disp_ext) && held_ptr == $past(ptr_val);
  endproperty
  a_disp: assert property (p_disp) else $error("displaced address wrong");

  property p_store;
    go && is_dm_wr(instr.op) && instr.op != LSX_OP_PUSH
      |=> dm_req.we && !dm_req.re && dm_req.wdata == $past(src_val) ##1 ready && !dm_req.we;
  endproperty
  a_store: assert property (p_store) else $error("store write wrong");

  property p_pm_three;
    go && op_pm |=> pm_re && pm_addr == $past(ptr_val) && !ready ##1 !ready ##1 ready && done;
  endproperty
  a_pm_three: assert property (p_pm_three) else $error("program read not three cycles");

  property p_push;
    go && instr.op == LSX_OP_PUSH && !cfg_we
      |=> dm_req.we && dm_req.addr == $past(sp_reg) && sp_reg == $past(sp_dec);
  endproperty
  a_push: assert property (p_push) else $error("push wrong");

  property p_io_bit;
    go && is_io(instr.op) |=> io_req.re && !ready ##1 io_req.we && ready
      && io_req.wdata[op_reg.bitsel] == (op_reg.op == LSX_OP_IO_BIT_SET);
  endproperty
  a_io_bit: assert property (p_io_bit) else $error("io bit write wrong");

  property p_shl;
    go && instr.op == LSX_OP_LOGICAL_SHIFT_LEFT |=> flags_reg[LSX_FLAG_C] == $past(dst_val[LSX_MSB])
      && flags_reg[LSX_FLAG_V] == (flags_reg[LSX_FLAG_N] ^ flags_reg[LSX_FLAG_C]) && ready;
  endproperty
  a_shl: assert property (p_shl) else $error("left shift flags wrong");

  property p_shr;
    go && instr.op inside {LSX_OP_LOGICAL_SHIFT_RIGHT, LSX_OP_ROTATE_RIGHT_CARRY, LSX_OP_ARITH_SHIFT_RIGHT}
      |=> flags_reg[LSX_FLAG_C] == $past(dst_val[0]);
  endproperty
  a_shr: assert property (p_shr) else $error("right shift carry wrong");

  property p_bit_copy;
    go && instr.op == LSX_OP_BIT_TO_FLAG_COPY && !cfg_we |=> flags_reg[LSX_FLAG_T] == $past(src_bit)
      && (flags_reg | 8'h40) == ($past(flags_reg) | 8'h40);
  endproperty
  a_bit_copy: assert property (p_bit_copy) else $error("transfer flag copy wrong");

  property p_flag_set;
    go && instr.op == LSX_OP_FLAG_SET |=> flags_reg[$past(instr.bitsel)] && done;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_sleep;
    go && instr.op == LSX_OP_SLEEP |=> sleep_req && ready && done;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not one cycle");

  c_load_post: cover property (go && instr.op == LSX_OP_LOAD_INDIRECT && instr.amode == LSX_AM_POSTINC);
  c_pm_read: cover property (go && op_pm ##3 done);
  c_io_pair: cover property (go && is_io(instr.op) ##2 go && is_io(instr.op));
  c_store_pre: cover property (go && instr.op == LSX_OP_MEMORY_WRITE_INDIRECT && is_predec);

endmodule : lsx_exec
`default_nettype wire

// >>> verification/lsx_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module lsx_mem_model
  import lsx_pkg::*;
(
  // clock
  input wire logic clk,
  // data memory
  input wire lsx_dm_req_s dm_req,
  output logic [7:0] dm_rdata,
  // io registers
  input wire lsx_io_req_s io_req,
  output logic [7:0] io_rdata,
  // program memory
  input wire logic [LSX_AW-1:0] pm_addr,
  input wire logic pm_re,
  output logic [7:0] pm_rdata
);
  logic [7:0] dmem [256];
  logic [7:0] iom [64];
  logic [7:0] pd;
  logic pv;
  initial begin
    for (int i = 0; i < 256; i++) begin
      dmem[i] = 8'(i) ^ 8'h5a;
    end
    for (int i = 0; i < 64; i++) begin
      iom[i] = 8'(i);
    end
    pv = 1'b0;
    pd = 8'h00;
  end
  // outside a strobe the lines show the inverse, never stale data
  assign dm_rdata = dm_req.re ? dmem[dm_req.addr[7:0]] : ~dmem[dm_req.addr[7:0]];
  assign io_rdata = io_req.re ? iom[io_req.addr] : ~iom[io_req.addr];
  assign pm_rdata = pv ? pd : ~pd;
  always @(posedge clk) begin
    if (dm_req.we) begin
      dmem[dm_req.addr[7:0]] <= dm_req.wdata;
    end
    if (io_req.we) begin
      iom[io_req.addr] <= io_req.wdata;
    end
    // synchronous program memory, one cycle latency
    pv <= pm_re;
    pd <= pm_addr[7:0] ^ 8'hc3;
  end
endmodule : lsx_mem_model
`default_nettype wire

// >>> verification/tb_lsx_exec.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_lsx_exec
  import lsx_pkg::*;
;
  logic clk, rst, instr_valid, ready, done, pm_re, sleep_req, wdr_pulse, break_req, cfg_we, cfg_re;
  lsx_instr_s instr;
  lsx_dm_req_s dm_req;
  lsx_io_req_s io_req;
  logic [7:0] dm_rdata, io_rdata, pm_rdata, flags, cfg_wdata, cfg_rdata, f0;
  logic [15:0] pm_addr;
  logic [5:0] cfg_addr;
  logic [2:0] pulses;
  int n_errors = 0, checks = 0, cyc = 0, lat;

  lsx_exec DUT (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr), .ready(ready), .done(done),
    .dm_req(dm_req), .dm_rdata(dm_rdata), .io_req(io_req), .io_rdata(io_rdata), .pm_addr(pm_addr),
    .pm_re(pm_re), .pm_rdata(pm_rdata), .sleep_req(sleep_req), .wdr_pulse(wdr_pulse), .break_req(break_req),
    .flags(flags), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_we(cfg_we), .cfg_re(cfg_re),
    .cfg_rdata(cfg_rdata));
  lsx_mem_model MEM (.clk(clk), .dm_req(dm_req), .dm_rdata(dm_rdata), .io_req(io_req), .io_rdata(io_rdata),
    .pm_addr(pm_addr), .pm_re(pm_re), .pm_rdata(pm_rdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  function automatic lsx_instr_s mk(lsx_op_e op, logic [4:0] rd = 5'd0, logic [4:0] rr = 5'd0,
      logic [15:0] k = 16'h0000, logic [2:0] b = 3'd0, lsx_ptr_e p = LSX_PTR_Z, lsx_amode_e am = LSX_AM_PLAIN);
    mk = '{op: op, ptr: p, amode: am, rd: rd, rr: rr, disp: k[5:0], addr: k, io: k[5:0], bitsel: b};
  endfunction : mk

  // hold the request until ready is seen, then count cycles to done
  task automatic go(lsx_instr_s x, int n);
    logic rdy1;
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= x;
    #1;
    f0 = flags;
    for (int i = 0; i < 8 && ready !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    instr_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
      if (lat == 1) begin
        rdy1 = ready;
      end
    end while (done !== 1'b1 && lat < 8);
    pulses = {sleep_req, wdr_pulse, break_req};
    `CHK("latency", n, lat)
    // one-cycle ops keep ready up, longer ones drop it
    `CHK("ready", n == 1, rdy1)
  endtask : go

  task automatic wr(logic [5:0] a, logic [7:0] d);
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_we <= 1'b0;
  endtask : wr

  task automatic rchk(logic [5:0] a, logic [7:0] e);
    @(posedge clk);
    cfg_re <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_re <= 1'b0;
    #1;
    `CHK($sformatf("reg %h", a), e, cfg_rdata)
  endtask : rchk

  task automatic setp(logic [4:0] lo, logic [15:0] v);
    wr({1'b0, lo}, v[7:0]);
    wr({1'b0, lo} + 6'h01, v[15:8]);
  endtask : setp

  task automatic pchk(logic [4:0] lo, logic [15:0] v);
    rchk({1'b0, lo}, v[7:0]);
    rchk({1'b0, lo} + 6'h01, v[15:8]);
  endtask : pchk

  // one load or store: pointer set, transfer, data and pointer judged
  task automatic xfer(bit st, lsx_op_e op, lsx_ptr_e p, lsx_amode_e am, logic [4:0] lo, logic [15:0] pv,
      logic [15:0] k, logic [15:0] ea, logic [15:0] np);
    setp(lo, pv);
    wr(6'h02, ~(ea[7:0] ^ 8'h5a));
    go(mk(op, 5'd5, 5'd2, k, 3'd0, p, am), 2);
    `CHK("flags", f0, flags)
    if (st) begin
      `CHK("stored", ~(ea[7:0] ^ 8'h5a), MEM.dmem[ea[7:0]])
    end else begin
      rchk(6'h05, ea[7:0] ^ 8'h5a);
    end
    pchk(lo, np);
  endtask : xfer

  task automatic t_reset();
    #1;
    `CHK("flags", LSX_FLAGS_RESET, flags)
    rchk(LSX_CFG_SP_HI, LSX_SP_RESET[15:8]);
    rchk(6'h3f, 8'h00);
  endtask : t_reset

  task automatic t_stack();
    wr(6'h03, 8'h3c);
    go(mk(LSX_OP_PUSH, 5'd0, 5'd3), 2);
    `CHK("push", 8'h3c, MEM.dmem[LSX_SP_RESET[7:0]])
    rchk(LSX_CFG_SP_LO, LSX_SP_RESET[7:0] - 8'h01);
    go(mk(LSX_OP_POP, 5'd4), 2);
    `CHK("flags", f0, flags)
    rchk(6'h04, 8'h3c);
    rchk(LSX_CFG_SP_LO, LSX_SP_RESET[7:0]);
  endtask : t_stack

  task automatic t_xfer();
    wr(LSX_CFG_FLAGS, 8'h55);
    xfer(0, LSX_OP_LOAD_INDIRECT, LSX_PTR_Z, LSX_AM_POSTINC, LSX_PTR_Z_LO, 16'h0010, 0, 16'h0010, 16'h0011);
    xfer(0, LSX_OP_LOAD_INDIRECT, LSX_PTR_X, LSX_AM_PREDEC, LSX_PTR_X_LO, 16'h0021, 0, 16'h0020, 16'h0020);
    xfer(0, LSX_OP_LOAD_INDIRECT, LSX_PTR_Y, LSX_AM_DISP, LSX_PTR_Y_LO, 16'h0040, 16'h003f, 16'h007f, 16'h0040);
    xfer(0, LSX_OP_LOAD_DIRECT, LSX_PTR_Z, LSX_AM_PLAIN, LSX_PTR_Z_LO, 16'h0011, 16'h00c8, 16'h00c8, 16'h0011);
    xfer(1, LSX_OP_MEMORY_WRITE_INDIRECT, LSX_PTR_X, LSX_AM_POSTINC, LSX_PTR_X_LO, 16'h0030, 0, 16'h0030, 16'h0031);
    xfer(1, LSX_OP_MEMORY_WRITE_INDIRECT, LSX_PTR_Y, LSX_AM_PREDEC, LSX_PTR_Y_LO, 16'h0041, 0, 16'h0040, 16'h0040);
    xfer(1, LSX_OP_MEMORY_WRITE_INDIRECT, LSX_PTR_Z, LSX_AM_DISP, LSX_PTR_Z_LO, 16'h0050, 16'h003f, 16'h008f, 16'h0050);
    xfer(1, LSX_OP_WRITE_DIRECT, LSX_PTR_Z, LSX_AM_PLAIN, LSX_PTR_Z_LO, 16'h0050, 16'h00c0, 16'h00c0, 16'h0050);
    xfer(1, LSX_OP_MEMORY_WRITE_INDIRECT, LSX_PTR_X, LSX_AM_PLAIN, LSX_PTR_X_LO, 16'h0060, 0, 16'h0060, 16'h0060);
  endtask : t_xfer

  task automatic t_pmem();
    setp(LSX_PTR_Z_LO, 16'h0005);
    go(mk(LSX_OP_PROGRAM_MEMORY_READ), 3);
    rchk(6'h00, 8'h05 ^ 8'hc3);
    setp(LSX_PTR_Z_LO, 16'h00ff);
    go(mk(LSX_OP_PROGRAM_MEMORY_READ, 5'd12, 5'd0, 16'h0000, 3'd0, LSX_PTR_Z, LSX_AM_POSTINC), 3);
    `CHK("flags", f0, flags)
    rchk(6'h0c, 8'hff ^ 8'hc3);
    pchk(LSX_PTR_Z_LO, 16'h0100);
  endtask : t_pmem

  task automatic t_io();
    MEM.iom[5] = 8'h5a;
    go(mk(LSX_OP_IO_BIT_SET, 5'd0, 5'd0, 16'h0005, 3'd0), 2);
    @(posedge clk);
    #1;
    `CHK("io set", 8'h5b, MEM.iom[5])
    go(mk(LSX_OP_IO_BIT_CLEAR, 5'd0, 5'd0, 16'h0005, 3'd6), 2);
    @(posedge clk);
    #1;
    `CHK("io clear", 8'h1b, MEM.iom[5])
    `CHK("flags", f0, flags)
  endtask : t_io

  task automatic t_shift();
    lsx_op_e ops [5] = '{LSX_OP_LOGICAL_SHIFT_LEFT, LSX_OP_LOGICAL_SHIFT_RIGHT, LSX_OP_ROTATE_LEFT_CARRY,
      LSX_OP_ROTATE_RIGHT_CARRY, LSX_OP_ARITH_SHIFT_RIGHT};
    logic [7:0] res [5] = '{8'h00, 8'h40, 8'h01, 8'hc0, 8'hc0};
    logic [7:0] fl [5] = '{8'h7b, 8'h70, 8'h79, 8'h7c, 8'h7c};
    for (int i = 0; i < 5; i++) begin
      wr(6'h07, 8'h80);
      wr(LSX_CFG_FLAGS, 8'h71);
      go(mk(ops[i], 5'd7), 1);
      `CHK("shift flags", fl[i], flags)
      rchk(6'h07, res[i]);
    end
  endtask : t_shift

  task automatic t_bits();
    wr(LSX_CFG_FLAGS, 8'h00);
    wr(6'h09, 8'h08);
    go(mk(LSX_OP_BIT_TO_FLAG_COPY, 5'd0, 5'd9, 16'h0000, 3'd3), 1);
    `CHK("transfer", 8'h40, flags)
    wr(6'h0a, 8'h00);
    go(mk(LSX_OP_FLAG_TO_BIT_COPY, 5'd10, 5'd0, 16'h0000, 3'd5), 1);
    `CHK("flags", 8'h40, flags)
    rchk(6'h0a, 8'h20);
  endtask : t_bits

  task automatic t_flags();
    for (int b = 0; b < 8; b++) begin
      wr(LSX_CFG_FLAGS, 8'h00);
      go(mk(LSX_OP_FLAG_SET, 5'd0, 5'd0, 16'h0000, 3'(b)), 1);
      `CHK("flag set", 8'h01 << b, flags)
      wr(LSX_CFG_FLAGS, 8'hff);
      go(mk(LSX_OP_FLAG_CLEAR, 5'd0, 5'd0, 16'h0000, 3'(b)), 1);
      `CHK("flag clear", ~(8'h01 << b), flags)
    end
  endtask : t_flags

  task automatic t_ctrl();
    lsx_op_e ops [4] = '{LSX_OP_NOP, LSX_OP_SLEEP, LSX_OP_WATCHDOG_RESTART, LSX_OP_BREAK};
    logic [2:0] ep [4] = '{3'b000, 3'b100, 3'b010, 3'b001};
    wr(LSX_CFG_FLAGS, 8'h96);
    for (int i = 0; i < 4; i++) begin
      go(mk(ops[i]), 1);
      `CHK("pulse", ep[i], pulses)
      `CHK("flags", 8'h96, flags)
    end
  endtask : t_ctrl

  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    cfg_we = 1'b0;
    cfg_re = 1'b0;
    cfg_addr = 6'h00;
    cfg_wdata = 8'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_stack();
    t_xfer();
    t_pmem();
    t_io();
    t_shift();
    t_bits();
    t_flags();
    t_ctrl();
    wrap_up();
  end
endmodule : tb_lsx_exec
`default_nettype wire
